/* File: panel_seq_regs.vh */
// Register map, field layout, reset values and timing figures of the panel supervisor.
// Assumes a 20 MHz core clock and an I2C host on the two-wire pins.
// Operation
// [RULE_01] Negative rail above short limit beyond qualifying time: flag, shut down, retry thrice.
// [RULE_02] Fault still present after retries: stay off, ignore enable until power-on reset.
// [RULE_03] Register 07h selects negative rail -4V to -13V in 0.5V steps, reset -8V.
// [RULE_04] Register 05h holds precharge mode and setpoint 3V to 6.5V, reset 6.5V.
// [RULE_05] Precharge output under a fifth of setpoint too long: shut down, retry, latch.
// [RULE_06] Modulated gate follows control input, held low until positive rail is ready.
// [RULE_07] At limit level stop discharging, float output until control input rises again.
// [RULE_08] Overcurrent or boost sense over reference releases protect output, latched till POR.
// [RULE_09] Register 06h sets protect start delay 0ms to 50ms in 10ms steps.
// [RULE_10] Register 07h sets protect end delay from 0ms up to 300ms.
// [RULE_11] First rise of panel supply sense starts timing start and end delays.
// [RULE_12] Normal order: switch low at start delay, released high at end delay.
// [RULE_13] Normal order: panel reset released a fixed 1ms after switch release.
// [RULE_14] Reverse order: switch stays high, panel reset released 1ms after end delay.
// [RULE_15] All counters, fault, retry and latch states clear on power-on reset.
`ifndef PANEL_SEQ_REGS_VH
`define PANEL_SEQ_REGS_VH

`define REG_PRECHARGE 8'h05
`define REG_START_DLY 8'h06
`define REG_NEG_END 8'h07

// Register 05h: bit 7 amplifier mode, bits 2:0 setpoint code (3V + code x 0.5V)
`define PRE_MODE_BIT 7
`define PRE_CODE_MSB 2
`define PRE_RESET 8'h07
// Register 06h: bits 2:0 start delay code, 10ms per step, codes above 5 act as 5
`define STR_CODE_MSB 2
`define STR_CODE_MAX 3'h5
`define STR_STEP_MS 9'h00A
`define STR_RESET 8'h00
// Register 07h: bits 4:0 rail code (-4V - code x 0.5V), bits 7:5 end delay code, 50ms per step
`define NEG_CODE_MSB 4
`define NEG_CODE_MAX 5'h12
`define END_CODE_LSB 5
`define END_CODE_MAX 3'h6
`define END_STEP_MS 9'h032
`define NEG_END_RESET 8'h48

`define CLK_NS 50
`define QUAL_NS 10000
`define QUAL_CYC ((`QUAL_NS + `CLK_NS - 1) / `CLK_NS)
`define MS_NS 1000000
`define MS_CYC (`MS_NS / `CLK_NS)
`define RST_DLY_MS 9'h001
`define RESTART_MS 9'h001
`define RETRY_MAX 2'h3
`define SETTLE_CYC 2'h3

`endif

/* File: panel_supervisor.v */
// Fault timing, protect latch, gate modulation control, panel sequencing and I2C registers.
// Assumes comparator outputs and pins arrive asynchronously; rst is the power-on reset.
`timescale 1ns/1ps
`include "panel_seq_regs.vh"

module fault_retry #(
  parameter QUAL = `QUAL_CYC,
  parameter MS_W = 9
) (
  input wire clock,
  input wire rst,
  input wire faultIn,
  input wire msTick,
  output wire runEn,
  output reg latchedOff_q,
  output reg shortFlag_q
);
  localparam F_RUN = 3'b001;
  localparam F_OFF = 3'b010;
  localparam F_LATCH = 3'b100;
  reg [2:0] state_q;
  reg [15:0] qualCnt_q;
  reg [1:0] retry_q;
  reg [MS_W-1:0] offMs_q;

  assign runEn = state_q[0];

  always @(posedge clock) begin
    if (rst) begin
      state_q <= F_RUN; // RULE_15
      qualCnt_q <= 16'h0000;
      retry_q <= 2'h0;
      offMs_q <= {MS_W{1'b0}};
      latchedOff_q <= 1'b0;
      shortFlag_q <= 1'b0;
    end else begin
      case (state_q)
        F_RUN: begin
          if (!faultIn) begin
            qualCnt_q <= 16'h0000;
          end else if (qualCnt_q == QUAL[15:0]) begin
            // Fault held for more than the qualifying time
            qualCnt_q <= 16'h0000;
            shortFlag_q <= 1'b1; // RULE_01
            offMs_q <= {MS_W{1'b0}};
            if (retry_q == `RETRY_MAX) begin
              state_q <= F_LATCH; // RULE_02
              latchedOff_q <= 1'b1;
            end else begin
              retry_q <= retry_q + 2'h1; // RULE_01
              state_q <= F_OFF;
            end
          end else begin
            qualCnt_q <= qualCnt_q + 16'h0001;
          end
        end
        F_OFF: begin
          if (msTick) begin
            if (offMs_q == `RESTART_MS - 9'h001) begin
              state_q <= F_RUN;
            end else begin
              offMs_q <= offMs_q + {{(MS_W-1){1'b0}}, 1'b1};
            end
          end
        end
        F_LATCH: begin
          // Only power-on reset leaves this state
          state_q <= F_LATCH; // RULE_02
        end
        default: begin
          state_q <= F_LATCH;
        end
      endcase
    end
  end
endmodule

module panel_supervisor #(
  parameter MS_CYC = `MS_CYC,
  parameter DEV_ADDR = 7'h20
) (
  input wire clock,
  input wire rst,
  input wire sclIn,
  input wire sdaI,
  output wire sdaO,
  output reg sdaOeN_q,
  input wire enableReqIn,
  input wire negRailShortIn,
  input wire prechargeLowIn,
  input wire posRailReadyIn,
  input wire gateModCtrlIn,
  input wire modLimitReachedIn,
  input wire inductorOverIn,
  input wire boostSenseOverIn,
  input wire panelSupplySenseIn,
  output reg railsEnable_q,
  output wire negShortFlag,
  output wire prechargeShortFlag,
  output wire faultLatched,
  output wire [4:0] negRailCode,
  output wire [2:0] prechargeCode,
  output wire prechargeMode,
  output reg gateChargeOut_q,
  output reg gateDischargeOut_q,
  output wire latchedProtectO,
  output reg latchedProtectOeN_q,
  output wire switchCtrlO,
  output reg switchCtrlOeN_q,
  output wire panelResetO,
  output reg panelResetOeN_q
);
  // Two-stage synchronisers for every asynchronous input
  localparam NSYNC = 11;
  wire [NSYNC-1:0] rawIn = {sclIn, sdaI, enableReqIn, negRailShortIn, prechargeLowIn,
    posRailReadyIn, gateModCtrlIn, modLimitReachedIn, inductorOverIn,
    boostSenseOverIn, panelSupplySenseIn};
  reg [NSYNC-1:0] syncA_q;
  reg [NSYNC-1:0] syncB_q;
  always @(posedge clock) begin
    if (rst) begin
      // Bus pins start at their idle high level so no false edge follows reset
      syncA_q <= {2'b11, {(NSYNC-2){1'b0}}};
      syncB_q <= {2'b11, {(NSYNC-2){1'b0}}};
    end else begin
      syncA_q <= rawIn;
      syncB_q <= syncA_q;
    end
  end
  wire sclQ = syncB_q[10];
  wire sdaQ = syncB_q[9];
  wire enReqQ = syncB_q[8];
  wire negShortQ = syncB_q[7];
  wire preLowQ = syncB_q[6];
  wire posReadyQ = syncB_q[5];
  wire modCtrlQ = syncB_q[4];
  wire limitQ = syncB_q[3];
  wire indOverQ = syncB_q[2];
  wire boostOverQ = syncB_q[1];
  wire senseQ = syncB_q[0];

  assign sdaO = 1'b0;
  assign latchedProtectO = 1'b0;
  assign switchCtrlO = 1'b0;
  assign panelResetO = 1'b0;

  // Millisecond prescaler, restarted when the sequencer starts a timing phase
  reg [15:0] msPre_q;
  reg seqRestart_q;
  // A tick on the restart edge would count a millisecond before the phase began
  wire msTick = (msPre_q == MS_CYC[15:0] - 16'h0001) && !seqRestart_q;
  always @(posedge clock) begin
    if (rst || seqRestart_q || msTick) begin
      msPre_q <= 16'h0000; // RULE_15
    end else begin
      msPre_q <= msPre_q + 16'h0001;
    end
  end

  // Register file
  reg [7:0] preReg_q;
  reg [7:0] strReg_q;
  reg [7:0] negEndReg_q;
  assign prechargeMode = preReg_q[`PRE_MODE_BIT]; // RULE_04
  assign prechargeCode = preReg_q[`PRE_CODE_MSB:0]; // RULE_04
  // Codes past -13V are clamped so the converter never sees an undefined setpoint
  assign negRailCode = (negEndReg_q[`NEG_CODE_MSB:0] > `NEG_CODE_MAX) ?
    `NEG_CODE_MAX : negEndReg_q[`NEG_CODE_MSB:0]; // RULE_03

  wire [2:0] strCode = (strReg_q[`STR_CODE_MSB:0] > `STR_CODE_MAX) ?
    `STR_CODE_MAX : strReg_q[`STR_CODE_MSB:0];
  wire [2:0] endCodeRaw = negEndReg_q[7:`END_CODE_LSB];
  wire [2:0] endCode = (endCodeRaw > `END_CODE_MAX) ? `END_CODE_MAX : endCodeRaw;
  wire [8:0] startMs = {6'h00, strCode} * `STR_STEP_MS; // RULE_09
  wire [8:0] endMs = {6'h00, endCode} * `END_STEP_MS; // RULE_10

  // Fault supervision of the two shorted-output detectors
  wire negRun;
  wire preRun;
  wire negLatched;
  wire preLatched;
  fault_retry #(.QUAL(`QUAL_CYC), .MS_W(9)) negFault (
    .clock(clock),
    .rst(rst),
    .faultIn(negShortQ), // RULE_01
    .msTick(msTick),
    .runEn(negRun),
    .latchedOff_q(negLatched),
    .shortFlag_q(negShortFlag)
  );
  fault_retry #(.QUAL(`QUAL_CYC), .MS_W(9)) preFault (
    .clock(clock),
    .rst(rst),
    .faultIn(preLowQ), // RULE_05
    .msTick(msTick),
    .runEn(preRun),
    .latchedOff_q(preLatched),
    .shortFlag_q(prechargeShortFlag)
  );
  assign faultLatched = negLatched | preLatched;

  always @(posedge clock) begin
    if (rst) begin
      railsEnable_q <= 1'b0;
    end else begin
      // A latched fault holds the rails enable off whatever the enable request
      railsEnable_q <= enReqQ & negRun & preRun & ~faultLatched; // RULE_02
    end
  end

  // Gate pulse modulation
  reg startDone_q;
  reg modPrev_q;
  reg floating_q;
  always @(posedge clock) begin
    if (rst) begin
      startDone_q <= 1'b0;
      modPrev_q <= 1'b0;
      floating_q <= 1'b0;
      gateChargeOut_q <= 1'b0;
      gateDischargeOut_q <= 1'b1;
    end else begin
      modPrev_q <= modCtrlQ;
      if (posReadyQ) begin
        startDone_q <= 1'b1; // RULE_06
      end
      if (modCtrlQ && !modPrev_q) begin
        floating_q <= 1'b0; // RULE_07
      end else if (limitQ && !modCtrlQ && startDone_q) begin
        floating_q <= 1'b1; // RULE_07
      end
      gateChargeOut_q <= startDone_q & modCtrlQ & railsEnable_q; // RULE_06
      gateDischargeOut_q <= ~startDone_q | (~modCtrlQ & ~floating_q &
        ~(limitQ & ~modCtrlQ)); // RULE_07
    end
  end

  // Protect output, released high on overcurrent and held until power-on reset
  always @(posedge clock) begin
    if (rst) begin
      latchedProtectOeN_q <= 1'b0;
    end else if (indOverQ || boostOverQ) begin
      latchedProtectOeN_q <= 1'b1; // RULE_08
    end
  end

  // Panel supply sequencer
  localparam S_INIT = 5'b00001;
  localparam S_WAIT = 5'b00010;
  localparam S_TIME = 5'b00100;
  localparam S_RST = 5'b01000;
  localparam S_DONE = 5'b10000;
  reg [4:0] seq_q;
  reg [1:0] settle_q;
  reg reverse_q;
  reg [8:0] msCnt_q;
  always @(posedge clock) begin
    if (rst) begin
      seq_q <= S_INIT; // RULE_15
      settle_q <= 2'h0;
      reverse_q <= 1'b0;
      msCnt_q <= 9'h000;
      seqRestart_q <= 1'b0;
      switchCtrlOeN_q <= 1'b1;
      panelResetOeN_q <= 1'b0;
    end else begin
      seqRestart_q <= 1'b0;
      case (seq_q)
        S_INIT: begin
          // Wait for the synchronisers to fill before judging supply order
          if (settle_q == `SETTLE_CYC) begin
            if (senseQ) begin
              reverse_q <= 1'b1; // RULE_14
              seq_q <= S_TIME;
              seqRestart_q <= 1'b1;
            end else begin
              seq_q <= S_WAIT;
            end
          end else begin
            settle_q <= settle_q + 2'h1;
          end
        end
        S_WAIT: begin
          if (senseQ) begin
            seq_q <= S_TIME; // RULE_11
            seqRestart_q <= 1'b1;
            msCnt_q <= 9'h000;
          end
        end
        S_TIME: begin
          if (msCnt_q >= endMs) begin
            switchCtrlOeN_q <= 1'b1; // RULE_12
            msCnt_q <= 9'h000;
            seqRestart_q <= 1'b1;
            seq_q <= S_RST;
          end else begin
            if (!reverse_q && msCnt_q >= startMs) begin
              switchCtrlOeN_q <= 1'b0; // RULE_12
            end
            if (msTick) begin
              msCnt_q <= msCnt_q + 9'h001;
            end
          end
        end
        S_RST: begin
          if (msCnt_q >= `RST_DLY_MS) begin
            panelResetOeN_q <= 1'b1; // RULE_13 RULE_14
            seq_q <= S_DONE;
          end else if (msTick) begin
            msCnt_q <= msCnt_q + 9'h001;
          end
        end
        S_DONE: begin
          seq_q <= S_DONE;
        end
        default: begin
          seq_q <= S_INIT;
        end
      endcase
    end
  end

  // I2C slave for the register file
  localparam I_IDLE = 7'b0000001;
  localparam I_ADDR = 7'b0000010;
  localparam I_REG = 7'b0000100;
  localparam I_WDAT = 7'b0001000;
  localparam I_ACK = 7'b0010000;
  localparam I_RDAT = 7'b0100000;
  localparam I_RACK = 7'b1000000;
  reg [6:0] ist_q;
  reg [6:0] inext_q;
  reg sclPrev_q;
  reg sdaPrev_q;
  reg [7:0] sh_q;
  reg [2:0] bitCnt_q;
  reg got_q;
  reg rack_q;
  reg [7:0] ptr_q;
  reg [7:0] rdData;
  wire startCond = sclQ & sclPrev_q & sdaPrev_q & ~sdaQ;
  wire stopCond = sclQ & sclPrev_q & ~sdaPrev_q & sdaQ;
  wire sclRise = sclQ & ~sclPrev_q;
  wire sclFall = ~sclQ & sclPrev_q;

  always @* begin
    case (ptr_q)
      `REG_PRECHARGE: rdData = preReg_q;
      `REG_START_DLY: rdData = strReg_q;
      `REG_NEG_END: rdData = negEndReg_q;
      default: rdData = 8'h00;
    endcase
  end

  always @(posedge clock) begin
    if (rst) begin
      ist_q <= I_IDLE;
      inext_q <= I_IDLE;
      sclPrev_q <= 1'b1;
      sdaPrev_q <= 1'b1;
      sh_q <= 8'h00;
      bitCnt_q <= 3'h0;
      got_q <= 1'b0;
      rack_q <= 1'b0;
      ptr_q <= 8'h00;
      sdaOeN_q <= 1'b1;
      preReg_q <= `PRE_RESET; // RULE_04
      strReg_q <= `STR_RESET;
      negEndReg_q <= `NEG_END_RESET; // RULE_03
    end else begin
      sclPrev_q <= sclQ;
      sdaPrev_q <= sdaQ;
      if (startCond) begin
        ist_q <= I_ADDR;
        bitCnt_q <= 3'h0;
        got_q <= 1'b0;
        rack_q <= 1'b0;
        sdaOeN_q <= 1'b1;
      end else if (stopCond) begin
        ist_q <= I_IDLE;
        sdaOeN_q <= 1'b1;
      end else if (ist_q == I_ADDR || ist_q == I_REG || ist_q == I_WDAT) begin
        if (sclRise) begin
          sh_q <= {sh_q[6:0], sdaQ};
          bitCnt_q <= bitCnt_q + 3'h1;
          got_q <= (bitCnt_q == 3'h7);
        end else if (sclFall && got_q) begin
          got_q <= 1'b0;
          ist_q <= I_ACK;
          sdaOeN_q <= 1'b0;
          if (ist_q == I_ADDR) begin
            if (sh_q[7:1] != DEV_ADDR) begin
              ist_q <= I_IDLE;
              sdaOeN_q <= 1'b1;
            end
            inext_q <= sh_q[0] ? I_RDAT : I_REG;
          end else if (ist_q == I_REG) begin
            ptr_q <= sh_q;
            inext_q <= I_WDAT;
          end else begin
            // Unmapped addresses take the write and drop it
            case (ptr_q)
              `REG_PRECHARGE: preReg_q <= sh_q; // RULE_04
              `REG_START_DLY: strReg_q <= sh_q; // RULE_09
              `REG_NEG_END: negEndReg_q <= sh_q; // RULE_03 RULE_10
              default: ptr_q <= ptr_q;
            endcase
            ptr_q <= ptr_q + 8'h01;
            inext_q <= I_WDAT;
          end
        end
      end else if (ist_q == I_ACK) begin
        if (sclFall) begin
          ist_q <= inext_q;
          bitCnt_q <= 3'h0;
          sdaOeN_q <= 1'b1;
          if (inext_q == I_RDAT) begin
            sh_q <= rdData;
            sdaOeN_q <= rdData[7];
            ptr_q <= ptr_q + 8'h01;
          end
        end
      end else if (ist_q == I_RDAT) begin
        if (sclFall) begin
          bitCnt_q <= bitCnt_q + 3'h1;
          if (bitCnt_q == 3'h7) begin
            sdaOeN_q <= 1'b1;
            ist_q <= I_RACK;
            rack_q <= 1'b1;
          end else begin
            sdaOeN_q <= sh_q[6];
            sh_q <= {sh_q[6:0], 1'b0};
          end
        end
      end else if (rack_q) begin
        // Host acknowledge decides whether another byte follows
        if (sclRise) begin
          rack_q <= 1'b0;
          ist_q <= sdaQ ? I_IDLE : I_ACK;
          inext_q <= I_RDAT;
        end
      end
    end
  end
endmodule

/* File: panel_supervisor_props.sv */
// Port-level checker for the panel supervisor.
// Assumes binding into panel_supervisor with its MS_CYC value handed on.
`timescale 1ns/1ps
module panel_supervisor_props #(
  parameter MS_CYC = 50
) (
  input wire clock,
  input wire rst,
  input wire negRailShortIn,
  input wire prechargeLowIn,
  input wire posRailReadyIn,
  input wire gateModCtrlIn,
  input wire modLimitReachedIn,
  input wire inductorOverIn,
  input wire boostSenseOverIn,
  input wire railsEnable_q,
  input wire negShortFlag,
  input wire prechargeShortFlag,
  input wire faultLatched,
  input wire gateChargeOut_q,
  input wire gateDischargeOut_q,
  input wire latchedProtectOeN_q,
  input wire switchCtrlOeN_q,
  input wire panelResetOeN_q
);
  localparam int RlsLo = MS_CYC - 3;
  localparam int RlsHi = MS_CYC + 3;
  logic [8:0] negRun_q;
  logic [8:0] preRun_q;
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  // Saturating run lengths of raw fault inputs, so a long fault never wraps
  always @(posedge clock) begin
    if (rst || !negRailShortIn) negRun_q <= 9'h000;
    else if (negRun_q != 9'h1FF) negRun_q <= negRun_q + 9'h001;
    if (rst || !prechargeLowIn) preRun_q <= 9'h000;
    else if (preRun_q != 9'h1FF) preRun_q <= preRun_q + 9'h001;
  end
  neg_qual_a:
    assert property ($rose(negShortFlag) |-> negRun_q >= 9'h0C8) else $error("early neg flag");
  pre_qual_a:
    assert property ($rose(prechargeShortFlag) |-> preRun_q >= 9'h0C8) else $error("early pre flag");
  latch_off_a:
    assert property (faultLatched [*2] |-> !railsEnable_q) else $error("rails on while latched");
  latch_hold_a:
    assert property (faultLatched |=> faultLatched) else $error("fault latch dropped");
  protect_set_a:
    assert property (inductorOverIn [*3] |-> ##[0:3] latchedProtectOeN_q)
      else $error("protect not released");
  boost_set_a:
    assert property (boostSenseOverIn [*3] |-> ##[0:3] latchedProtectOeN_q)
      else $error("protect not released on boost sense");
  protect_hold_a:
    assert property (latchedProtectOeN_q |=> latchedProtectOeN_q) else $error("protect dropped");
  gate_low_a:
    assert property (!gateModCtrlIn [*4] |-> !gateChargeOut_q) else $error("charge without ctrl");
  gate_float_a:
    assert property ((posRailReadyIn && modLimitReachedIn && !gateModCtrlIn) [*6]
      |-> !gateDischargeOut_q) else $error("discharge past limit");
  reset_delay_a:
    assert property ($rose(switchCtrlOeN_q) |-> ##[RlsLo:RlsHi] $rose(panelResetOeN_q))
      else $error("panel reset delay wrong");
  switch_first_a:
    assert property ($rose(panelResetOeN_q) |-> switchCtrlOeN_q) else $error("reset before switch");
endmodule

/* File: i2c_host_model.sv */
// I2C host model for the supervisor's two-wire register port.
// Assumes the bench resolves the open-drain data line; released means pulled high.
`timescale 1ns/1ps
module i2c_host_model #(
  parameter logic [6:0] DEV_ADDR = 7'h20
) (
  input wire clock,
  input wire sdaLine,
  output logic scl,
  output logic sdaHost
);
  initial begin
    scl = 1'b1;
    sdaHost = 1'b1;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  // Eight clocks low and eight high, twice the minimum the port needs
  task automatic bit_io(input logic b, output logic got);
    sdaHost = b;
    tick(6);
    scl = 1'b1;
    tick(4);
    got = sdaLine;
    tick(4);
    scl = 1'b0;
    tick(2);
  endtask
  task automatic byte_io(input logic [7:0] tx, output logic [7:0] rx);
    logic a;
    for (int i = 7; i >= 0; i--) bit_io(tx[i], rx[i]);
    bit_io(1'b1, a);
  endtask
  task automatic start_cond();
    sdaHost = 1'b1;
    scl = 1'b1;
    tick(4);
    sdaHost = 1'b0;
    tick(4);
    scl = 1'b0;
    tick(2);
  endtask
  task automatic stop_cond();
    sdaHost = 1'b0;
    tick(4);
    scl = 1'b1;
    tick(4);
    sdaHost = 1'b1;
    tick(4);
  endtask
  task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
    logic [7:0] rx;
    start_cond();
    byte_io({DEV_ADDR, 1'b0}, rx);
    byte_io(addr, rx);
    byte_io(data, rx);
    stop_cond();
  endtask
  // Sets the pointer, then reads one byte and ends it with a NACK
  task automatic read_reg(input logic [7:0] addr, output logic [7:0] data);
    logic [7:0] rx;
    start_cond();
    byte_io({DEV_ADDR, 1'b0}, rx);
    byte_io(addr, rx);
    stop_cond();
    start_cond();
    byte_io({DEV_ADDR, 1'b1}, rx);
    byte_io(8'hFF, data);
    stop_cond();
  endtask
endmodule

/* File: tb_panel_supervisor.sv */
// Self-checking bench: registers, faults, gate control, protect latch, panel sequencing.
// Assumes i2c_host_model as register master and a 1ms prescale of MS cycles.
`timescale 1ns/1ps
module tb_panel_supervisor;
  localparam int MS = 50;
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] data;
    logic [7:0] rd;
    logic [7:0] neg;
    logic [7:0] pre;
    logic [7:0] mode;
  } row_t;
  row_t rows [8] = '{
    '{8'h07, 8'h52, 8'h52, 8'h12, 8'h07, 8'h00}, '{8'h07, 8'h40, 8'h40, 8'h00, 8'h07, 8'h00},
    '{8'h05, 8'h80, 8'h80, 8'h00, 8'h00, 8'h01}, '{8'h05, 8'h07, 8'h07, 8'h00, 8'h07, 8'h00},
    '{8'h08, 8'hAA, 8'h00, 8'h00, 8'h07, 8'h00}, '{8'h06, 8'h01, 8'h01, 8'h00, 8'h07, 8'h00},
    '{8'h07, 8'h3F, 8'h3F, 8'h12, 8'h07, 8'h00},
    '{8'h07, 8'h28, 8'h28, 8'h08, 8'h07, 8'h00}};
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic enableReqIn = 1'b0, negRailShortIn = 1'b0, prechargeLowIn = 1'b0, posRailReadyIn = 1'b0;
  logic gateModCtrlIn = 1'b0, modLimitReachedIn = 1'b0, inductorOverIn = 1'b0;
  logic boostSenseOverIn = 1'b0, panelSupplySenseIn = 1'b0;
  logic [7:0] rd;
  int err_total = 0;
  int n_compared = 0;
  int falls = 0;
  int swDrops = 0;
  int n;
  wire scl, sdaHost, sdaO, sdaOeN_q, railsEnable_q, negShortFlag, prechargeShortFlag;
  wire faultLatched, prechargeMode, gateChargeOut_q, gateDischargeOut_q, latchedProtectOeN_q;
  wire switchCtrlOeN_q, panelResetOeN_q;
  wire [4:0] negRailCode;
  wire [2:0] prechargeCode;
  wire sdaLine = sdaHost & (sdaOeN_q | sdaO);
  wire [2:0] watch = {panelResetOeN_q, switchCtrlOeN_q, faultLatched};
  always #25 clock = ~clock;
  always @(negedge railsEnable_q) falls++;
  always @(negedge switchCtrlOeN_q) swDrops++;
  i2c_host_model host (.clock(clock), .sdaLine(sdaLine), .scl(scl), .sdaHost(sdaHost));
  panel_supervisor #(.MS_CYC(MS)) DUT (
    .clock(clock), .rst(rst), .sclIn(scl), .sdaI(sdaLine), .sdaO(sdaO), .sdaOeN_q(sdaOeN_q),
    .enableReqIn(enableReqIn), .negRailShortIn(negRailShortIn), .prechargeLowIn(prechargeLowIn),
    .posRailReadyIn(posRailReadyIn), .gateModCtrlIn(gateModCtrlIn),
    .modLimitReachedIn(modLimitReachedIn), .inductorOverIn(inductorOverIn),
    .boostSenseOverIn(boostSenseOverIn), .panelSupplySenseIn(panelSupplySenseIn),
    .railsEnable_q(railsEnable_q), .negShortFlag(negShortFlag),
    .prechargeShortFlag(prechargeShortFlag), .faultLatched(faultLatched),
    .negRailCode(negRailCode), .prechargeCode(prechargeCode), .prechargeMode(prechargeMode),
    .gateChargeOut_q(gateChargeOut_q), .gateDischargeOut_q(gateDischargeOut_q),
    .latchedProtectO(), .latchedProtectOeN_q(latchedProtectOeN_q), .switchCtrlO(),
    .switchCtrlOeN_q(switchCtrlOeN_q), .panelResetO(), .panelResetOeN_q(panelResetOeN_q));
  task automatic tick(input int k);
    repeat (k) @(posedge clock);
    #1;
  endtask
  task automatic do_reset();
    rst = 1'b1;
    tick(20);
    rst = 1'b0;
    tick(3);
  endtask
  task automatic check_val(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Cycle counts carry the prescaler's restart jitter plus input synchronisation
  task automatic check_near(input int got, input int exp);
    n_compared++;
    if (got < exp - 6 || got > exp + 6) begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wait_bit(input int idx, input logic v, output int k);
    k = 0;
    while (watch[idx] !== v && k < 8000) begin
      tick(1);
      k++;
    end
  endtask
  task automatic finish_test();
    $display("compared=%0d mismatches=%0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    #3_000_000;
    err_total++;
    finish_test();
  end
  initial begin
    do_reset();
    check_val(negRailCode, 8'h08);
    check_val(latchedProtectOeN_q, 8'h00);
    host.read_reg(8'h05, rd);
    check_val(rd, 8'h07);
    host.read_reg(8'h06, rd);
    check_val(rd, 8'h00);
    host.read_reg(8'h07, rd);
    check_val(rd, 8'h48);
    foreach (rows[i]) begin
      host.write_reg(rows[i].addr, rows[i].data);
      host.read_reg(rows[i].addr, rd);
      check_val(rd, rows[i].rd);
      check_val(negRailCode, rows[i].neg);
      check_val(prechargeCode, rows[i].pre);
      check_val(prechargeMode, rows[i].mode);
    end
    panelSupplySenseIn = 1'b1;
    wait_bit(1, 1'b0, n);
    check_near(n, 10 * MS);
    wait_bit(1, 1'b1, n);
    check_near(n, 40 * MS);
    wait_bit(2, 1'b1, n);
    check_near(n, MS);
    enableReqIn = 1'b1;
    gateModCtrlIn = 1'b1;
    tick(8);
    check_val(gateChargeOut_q, 8'h00);
    posRailReadyIn = 1'b1;
    tick(8);
    check_val(gateChargeOut_q, 8'h01);
    gateModCtrlIn = 1'b0;
    tick(8);
    check_val(gateDischargeOut_q, 8'h01);
    modLimitReachedIn = 1'b1;
    tick(8);
    modLimitReachedIn = 1'b0;
    tick(8);
    check_val({gateChargeOut_q, gateDischargeOut_q}, 8'h00);
    gateModCtrlIn = 1'b1;
    tick(8);
    check_val(gateChargeOut_q, 8'h01);
    negRailShortIn = 1'b1;
    tick(150);
    negRailShortIn = 1'b0;
    tick(5);
    check_val(negShortFlag, 8'h00);
    falls = 0;
    negRailShortIn = 1'b1;
    tick(4 * (205 + MS) + 100);
    check_val(negShortFlag, 8'h01);
    check_val(falls, 8'h04);
    negRailShortIn = 1'b0;
    enableReqIn = 1'b0;
    tick(5);
    enableReqIn = 1'b1;
    tick(3 * MS);
    check_val({faultLatched, railsEnable_q}, 8'h02);
    do_reset();
    check_val({negShortFlag, faultLatched}, 8'h00);
    prechargeLowIn = 1'b1;
    tick(1400);
    prechargeLowIn = 1'b0;
    check_val({prechargeShortFlag, faultLatched}, 8'h03);
    do_reset();
    inductorOverIn = 1'b1;
    tick(3);
    inductorOverIn = 1'b0;
    tick(20);
    check_val(latchedProtectOeN_q, 8'h01);
    do_reset();
    boostSenseOverIn = 1'b1;
    tick(3);
    boostSenseOverIn = 1'b0;
    tick(20);
    check_val(latchedProtectOeN_q, 8'h01);
    panelSupplySenseIn = 1'b1;
    do_reset();
    swDrops = 0;
    wait_bit(2, 1'b1, n);
    check_near(n, 101 * MS);
    check_val(swDrops, 8'h00);
    finish_test();
  end
endmodule
bind panel_supervisor panel_supervisor_props #(.MS_CYC(MS_CYC)) props (
  .clock(clock), .rst(rst), .negRailShortIn(negRailShortIn), .prechargeLowIn(prechargeLowIn),
  .boostSenseOverIn(boostSenseOverIn),
  .posRailReadyIn(posRailReadyIn), .gateModCtrlIn(gateModCtrlIn),
  .modLimitReachedIn(modLimitReachedIn), .inductorOverIn(inductorOverIn),
  .railsEnable_q(railsEnable_q), .negShortFlag(negShortFlag),
  .prechargeShortFlag(prechargeShortFlag), .faultLatched(faultLatched),
  .gateChargeOut_q(gateChargeOut_q), .gateDischargeOut_q(gateDischargeOut_q),
  .latchedProtectOeN_q(latchedProtectOeN_q), .switchCtrlOeN_q(switchCtrlOeN_q),
  .panelResetOeN_q(panelResetOeN_q));
